// ---- rtl/lbgcr_gateway.sv ----
// top: external packet receiver, menu state and lamp command issue
`timescale 1ns/10ps
module lbgcr_gateway
   import lbgcr_pkg::*;
#(
   parameter int TIMEOUT_CYC = PKT_TIMEOUT_CYC,
   parameter int DIV_W = 16
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic rxPin,
   output logic txPin,
   input wire lbgcr_pkg::lbgcr_apb_req_s apbReq,
   output lbgcr_pkg::lbgcr_apb_rsp_s apbRsp,
   input wire logic [7:0] lampStatus,
   input wire logic lampResponding,
   input wire logic busOk,
   input wire logic [7:0] supplyVolts,
   output lbgcr_pkg::lbgcr_cmd_s extCmd,
   output lbgcr_pkg::lbgcr_cmd_s localCmd,
   output logic [3:0] panelAddr,
   output logic [5:0] selLamp
);
   import lbgcr_pkg::*;

   logic [7:0] rxByte;
   logic rxValid;
   logic [DIV_W-1:0] baudDiv_ff;
   logic [7:0] lampSt_ff;
   logic respond_ff;
   logic busOk_ff;
   logic [7:0] supply_ff;
   logic [7:0] lampStM_ff;
   logic respM_ff;
   logic busOkM_ff;
   logic [7:0] supplyM_ff;

   // ****************************************
   // byte receiver
   // ****************************************
   lbgcr_uart_rx #(.DIV_W(DIV_W)) i_lbgcr_uart_rx
   (
      .core_clk(core_clk),
      .reset(reset),
      .rxPin(rxPin),
      .bitDiv(baudDiv_ff),
      .byteData(rxByte),
      .byteValid(rxValid)
   );

   // lamp side inputs come from another domain
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         lampStM_ff <= 8'h00;
         lampSt_ff <= 8'h00;
         respM_ff <= 1'b0;
         respond_ff <= 1'b0;
         busOkM_ff <= 1'b0;
         busOk_ff <= 1'b0;
         supplyM_ff <= 8'h00;
         supply_ff <= 8'h00;
      end
      else
      begin
         lampStM_ff <= lampStatus;
         lampSt_ff <= lampStM_ff;
         respM_ff <= lampResponding;
         respond_ff <= respM_ff;
         busOkM_ff <= busOk;
         busOk_ff <= busOkM_ff;
         supplyM_ff <= supplyVolts;
         supply_ff <= supplyM_ff;
      end
   end

   // transmit line idles high; no reply path is started here
   always_ff @(posedge core_clk)
   begin
      txPin <= 1'b1;
   end

   // ****************************************
   // packet collector
   // ****************************************
   logic checkEn_ff;
   logic [2:0] cnt_ff;
   logic [2:0] need_ff;
   logic [7:0] sum_ff;
   logic [31:0] tmo_ff;
   logic [7:0] pAddr_ff;
   logic [7:0] pCmd_ff;
   logic [7:0] pD0_ff;
   logic [7:0] pD1_ff;
   logic [1:0] diag_ff;
   logic [4:0] diagLamp_ff;
   logic [7:0] diagCmd_ff;
   logic [15:0] diagCnt_ff;
   logic [2:0] cmdLen;

   function automatic logic [2:0] lenOf(input logic [7:0] c);
      case (c)
         CMD_PAN_CW, CMD_PAN_ACW, CMD_TILT_DN, CMD_TILT_UP: lenOf = 3'(PKT_MIN_LEN + 1);
         CMD_PAN_POS, CMD_TILT_POS: lenOf = 3'(PKT_MAX_LEN);
         CMD_FOCUS, CMD_HOME, CMD_RECORD, CMD_PLAY, CMD_STORE_HOME,
         CMD_LAMP_ON, CMD_LAMP_OFF, CMD_STATUS: lenOf = 3'(PKT_MIN_LEN);
         default: lenOf = 3'h0;
      endcase
   endfunction : lenOf

   assign cmdLen = lenOf(rxByte);

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cnt_ff <= 3'h0;
         need_ff <= 3'h0;
         sum_ff <= 8'h00;
         tmo_ff <= '0;
         pAddr_ff <= 8'h00;
         pCmd_ff <= 8'h00;
         pD0_ff <= 8'h00;
         pD1_ff <= 8'h00;
         extCmd <= '0;
         diag_ff <= DIAG_OK;
         diagLamp_ff <= 5'h00;
         diagCmd_ff <= 8'h00;
         diagCnt_ff <= 16'h0000;
      end
      else
      begin
         extCmd.valid <= 1'b0;
         if (cnt_ff != 3'h0)
            tmo_ff <= tmo_ff + 32'h1;
         if (cnt_ff != 3'h0 && tmo_ff >= 32'(TIMEOUT_CYC) && !rxValid)
            cnt_ff <= 3'h0;
         else if (rxValid)
         begin
            if (rxByte == SYNC_BYTE)
            begin
               cnt_ff <= 3'h1;
               sum_ff <= rxByte;
               tmo_ff <= '0;
            end
            else if (cnt_ff == 3'h1)
            begin
               if (rxByte >= LAMP_ADDR_MIN && rxByte <= LAMP_ADDR_MAX)
               begin
                  pAddr_ff <= rxByte;
                  sum_ff <= sum_ff + rxByte;
                  cnt_ff <= 3'h2;
               end
               else
               begin
                  cnt_ff <= 3'h0;
                  diag_ff <= DIAG_BAD_ADDR;
                  diagCnt_ff <= diagCnt_ff + 16'h1;
               end
            end
            else if (cnt_ff == 3'h2)
            begin
               if (cmdLen != 3'h0)
               begin
                  pCmd_ff <= rxByte;
                  need_ff <= cmdLen;
                  sum_ff <= sum_ff + rxByte;
                  cnt_ff <= 3'h3;
               end
               else
               begin
                  cnt_ff <= 3'h0;
                  diag_ff <= DIAG_BAD_CMD;
                  diagCnt_ff <= diagCnt_ff + 16'h1;
               end
            end
            else if (cnt_ff != 3'h0 && cnt_ff < need_ff - 3'h1)
            begin
               if (cnt_ff == 3'h3)
                  pD0_ff <= rxByte;
               else
                  pD1_ff <= rxByte;
               sum_ff <= sum_ff + rxByte;
               cnt_ff <= cnt_ff + 3'h1;
            end
            else if (cnt_ff != 3'h0)
            begin
               cnt_ff <= 3'h0;
               diagCnt_ff <= diagCnt_ff + 16'h1;
               diagLamp_ff <= 5'(pAddr_ff - LAMP_ADDR_MIN);
               diagCmd_ff <= pCmd_ff;
               if (checkEn_ff && rxByte[6:0] != (sum_ff[6:0] & CHK_MASK))
                  diag_ff <= DIAG_CHK_ERR;
               else
               begin
                  diag_ff <= DIAG_OK;
                  extCmd <= '{1'b1, pAddr_ff, pCmd_ff, pD0_ff, pD1_ff};
               end
            end
         end
      end
   end

   // ****************************************
   // menu and settings
   // ****************************************
   lbgcr_menu_e menu_ff;
   logic [3:0] pendPanel_ff;
   logic [5:0] pendLamp_ff;
   logic pendCheck_ff;
   logic pendOn_ff;
   logic [11:0] pendPan_ff;
   logic [11:0] pendTilt_ff;
   logic [6:0] focus_ff;
   logic [3:0] keyPulse;
   logic apbWr;

   assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
   assign keyPulse = (apbWr && apbReq.paddr[7:0] == REG_KEYS) ? apbReq.pwdata[3:0] : 4'h0;

   always_ff @(posedge core_clk)
   begin
      if (reset)
         menu_ff <= MENU_DEFAULT;
      else if (keyPulse[KEY_SEL])
      begin
         case (menu_ff)
            MENU_DEFAULT: menu_ff <= MENU_PANEL;
            MENU_PANEL: menu_ff <= MENU_LAMP;
            MENU_LAMP: menu_ff <= MENU_CHECK;
            MENU_CHECK: menu_ff <= MENU_SWITCH;
            MENU_SWITCH: menu_ff <= MENU_PAN;
            MENU_PAN: menu_ff <= MENU_TILT;
            MENU_TILT: menu_ff <= MENU_FOCUS;
            MENU_FOCUS: menu_ff <= MENU_EXT;
            MENU_EXT: menu_ff <= MENU_SUPPLY;
            default: menu_ff <= MENU_DEFAULT;
         endcase
      end
   end

   // pending values move with up/down; settings change only on commit
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         pendPanel_ff <= 4'h0;
         pendLamp_ff <= SEL_LAMP_MIN;
         pendCheck_ff <= 1'b1;
         pendOn_ff <= 1'b0;
         pendPan_ff <= ANGLE_CENTRE;
         pendTilt_ff <= ANGLE_CENTRE;
         panelAddr <= 4'h0;
         selLamp <= SEL_LAMP_MIN;
         checkEn_ff <= 1'b1;
      end
      else
      begin
         case (menu_ff)
            MENU_PANEL:
            begin
               if (keyPulse[KEY_UP] && pendPanel_ff != PANEL_ADDR_MAX)
                  pendPanel_ff <= pendPanel_ff + 4'h1;
               if (keyPulse[KEY_DOWN] && pendPanel_ff != 4'h0)
                  pendPanel_ff <= pendPanel_ff - 4'h1;
               if (keyPulse[KEY_COMMIT])
                  panelAddr <= pendPanel_ff;
            end
            MENU_LAMP:
            begin
               if (keyPulse[KEY_UP] && pendLamp_ff < SEL_LAMP_MAX)
                  pendLamp_ff <= pendLamp_ff + 6'h1;
               if (keyPulse[KEY_DOWN] && pendLamp_ff > SEL_LAMP_MIN)
                  pendLamp_ff <= pendLamp_ff - 6'h1;
               if (keyPulse[KEY_COMMIT])
                  selLamp <= pendLamp_ff;
            end
            MENU_CHECK:
            begin
               if (keyPulse[KEY_UP] || keyPulse[KEY_DOWN])
                  pendCheck_ff <= !pendCheck_ff;
               if (keyPulse[KEY_COMMIT])
                  checkEn_ff <= pendCheck_ff;
            end
            MENU_SWITCH:
               if (keyPulse[KEY_UP] || keyPulse[KEY_DOWN])
                  pendOn_ff <= keyPulse[KEY_UP];
            MENU_PAN:
            begin
               if (keyPulse[KEY_UP])
                  pendPan_ff <= pendPan_ff + 12'h1;
               if (keyPulse[KEY_DOWN])
                  pendPan_ff <= pendPan_ff - 12'h1;
            end
            MENU_TILT:
            begin
               if (keyPulse[KEY_UP])
                  pendTilt_ff <= pendTilt_ff + 12'h1;
               if (keyPulse[KEY_DOWN])
                  pendTilt_ff <= pendTilt_ff - 12'h1;
            end
            default: ;
         endcase
      end
   end

   // local lamp commands; addresses use the external 0x90 based form
   logic [7:0] selAddr;
   assign selAddr = LAMP_ADDR_MIN + {2'b00, selLamp - SEL_LAMP_MIN};

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         localCmd <= '0;
         focus_ff <= 7'h00;
      end
      else
      begin
         localCmd <= '0;
         if (keyPulse[KEY_COMMIT] && menu_ff == MENU_SWITCH)
            localCmd <= '{1'b1, selAddr, pendOn_ff ? CMD_LAMP_ON : CMD_LAMP_OFF,
                          8'h00, 8'h00};
         if (keyPulse[KEY_COMMIT] && menu_ff == MENU_PAN)
            localCmd <= '{1'b1, selAddr, CMD_PAN_POS, pendPan_ff[7:0],
                          {4'h0, pendPan_ff[11:8]}};
         if (keyPulse[KEY_COMMIT] && menu_ff == MENU_TILT)
            localCmd <= '{1'b1, selAddr, CMD_TILT_POS, pendTilt_ff[7:0],
                          {4'h0, pendTilt_ff[11:8]}};
         if (keyPulse[KEY_UP] && menu_ff == MENU_FOCUS)
         begin
            localCmd <= '{1'b1, selAddr, CMD_FOCUS, 8'h00, 8'h00};
            focus_ff <= (focus_ff >= FOCUS_MAX) ? 7'h00 : focus_ff + 7'h1;
         end
      end
   end

   // ****************************************
   // apb slave, zero wait states
   // ****************************************
   logic supplyBad;
   assign supplyBad = (supply_ff > SUPPLY_HI) || (supply_ff < SUPPLY_LO);

   always_ff @(posedge core_clk)
   begin
      if (reset)
         baudDiv_ff <= DIV_W'(CLK_HZ / BAUD_DEFAULT);
      else if (apbWr && apbReq.paddr[7:0] == REG_BAUD)
         baudDiv_ff <= apbReq.pwdata[DIV_W-1:0];
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         apbRsp <= '0;
      else
      begin
         apbRsp.pready <= apbReq.psel && !apbReq.penable;
         apbRsp.pslverr <= 1'b0;
         apbRsp.prdata <= 32'h0;
         if (apbReq.psel && !apbReq.penable)
         begin
            case (apbReq.paddr[7:0])
               REG_CTRL: apbRsp.prdata <= {16'h0, 2'b00, selLamp, 3'b000, checkEn_ff, panelAddr};
               REG_PEND: apbRsp.prdata <= {4'(menu_ff), pendOn_ff, pendCheck_ff,
                                           pendLamp_ff, pendPanel_ff, 1'b0, focus_ff, 8'h0};
               REG_KEYS: apbRsp.prdata <= {pendTilt_ff, 4'h0, pendPan_ff, 4'h0};
               REG_RXPKT: apbRsp.prdata <= {extCmd.addr, extCmd.cmd, extCmd.d0, extCmd.d1};
               REG_RXDIAG: apbRsp.prdata <= {diagCnt_ff, 1'b0, diagLamp_ff, diag_ff,
                                             diagCmd_ff};
               REG_LAMPST: apbRsp.prdata <= {22'h0, busOk_ff, respond_ff, lampSt_ff};
               REG_SUPPLY: apbRsp.prdata <= {23'h0, supplyBad, supply_ff};
               REG_BAUD: apbRsp.prdata <= 32'(baudDiv_ff);
               default: apbRsp.pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_tx_idle;
      @(posedge core_clk) disable iff (reset) txPin;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("tx left idle");

   property p_panel_range;
      @(posedge core_clk) disable iff (reset) panelAddr <= PANEL_ADDR_MAX;
   endproperty
   a_panel_range: assert property (p_panel_range) else $error("panel address range");

   property p_lamp_range;
      @(posedge core_clk) disable iff (reset)
         selLamp >= SEL_LAMP_MIN && selLamp <= SEL_LAMP_MAX;
   endproperty
   a_lamp_range: assert property (p_lamp_range) else $error("selected lamp range");

   property p_commit_only;
      @(posedge core_clk) disable iff (reset)
         !$past(keyPulse[KEY_COMMIT]) |-> $stable(selLamp) && $stable(panelAddr);
   endproperty
   a_commit_only: assert property (p_commit_only) else $error("setting changed without commit");

   property p_focus_wrap;
      @(posedge core_clk) disable iff (reset) focus_ff <= FOCUS_MAX;
   endproperty
   a_focus_wrap: assert property (p_focus_wrap) else $error("focus out of range");

   property p_ext_addr;
      @(posedge core_clk) disable iff (reset)
         extCmd.valid |-> extCmd.addr >= LAMP_ADDR_MIN && extCmd.addr <= LAMP_ADDR_MAX;
   endproperty
   a_ext_addr: assert property (p_ext_addr) else $error("bad address passed");

   property p_ext_cmd;
      @(posedge core_clk) disable iff (reset) extCmd.valid |-> lenOf(extCmd.cmd) != 3'h0;
   endproperty
   a_ext_cmd: assert property (p_ext_cmd) else $error("bad command passed");

   property p_switch_cmd;
      @(posedge core_clk) disable iff (reset)
         keyPulse[KEY_COMMIT] && menu_ff == MENU_SWITCH |=>
            localCmd.valid && localCmd.cmd == ($past(pendOn_ff) ? CMD_LAMP_ON : CMD_LAMP_OFF);
   endproperty
   a_switch_cmd: assert property (p_switch_cmd) else $error("switch command missing");

   property p_pan_cmd;
      @(posedge core_clk) disable iff (reset)
         keyPulse[KEY_COMMIT] && menu_ff == MENU_PAN |=>
            localCmd.valid && localCmd.cmd == CMD_PAN_POS && localCmd.d0 == $past(pendPan_ff[7:0]);
   endproperty
   a_pan_cmd: assert property (p_pan_cmd) else $error("pan command missing");
endmodule : lbgcr_gateway

// ---- rtl/lbgcr_pkg.sv ----
// package: constants, types and register map for the lamp bus gateway receiver
package lbgcr_pkg;
   // ****************************************
   // serial framing and timing
   // ****************************************
   localparam int CLK_HZ = 100000000;
   localparam int BAUD_DEFAULT = 9600;
   localparam int PKT_TIMEOUT_MS = 30;
   localparam int PKT_TIMEOUT_CYC = (CLK_HZ / 1000) * PKT_TIMEOUT_MS;
   localparam int DATA_BITS = 8;
   // ****************************************
   // packet layout
   // ****************************************
   localparam logic [7:0] SYNC_BYTE = 8'hFF;
   localparam logic [7:0] LAMP_ADDR_MIN = 8'h90;
   localparam logic [7:0] LAMP_ADDR_MAX = 8'hA8;
   localparam logic [6:0] CHK_MASK = 7'h7F;
   localparam int PKT_MIN_LEN = 4;
   localparam int PKT_MAX_LEN = 6;
   // ****************************************
   // lamp command codes
   // ****************************************
   localparam logic [7:0] CMD_FOCUS = 8'h0B;
   localparam logic [7:0] CMD_HOME = 8'h0C;
   localparam logic [7:0] CMD_RECORD = 8'h0D;
   localparam logic [7:0] CMD_PLAY = 8'h0E;
   localparam logic [7:0] CMD_STORE_HOME = 8'h0F;
   localparam logic [7:0] CMD_PAN_CW = 8'h14;
   localparam logic [7:0] CMD_PAN_ACW = 8'h15;
   localparam logic [7:0] CMD_TILT_DN = 8'h16;
   localparam logic [7:0] CMD_TILT_UP = 8'h17;
   localparam logic [7:0] CMD_PAN_POS = 8'h18;
   localparam logic [7:0] CMD_TILT_POS = 8'h19;
   localparam logic [7:0] CMD_LAMP_ON = 8'h1A;
   localparam logic [7:0] CMD_LAMP_OFF = 8'h1B;
   localparam logic [7:0] CMD_STATUS = 8'h1E;
   // ****************************************
   // settings ranges
   // ****************************************
   localparam logic [3:0] PANEL_ADDR_MAX = 4'hF;
   localparam logic [5:0] SEL_LAMP_MIN = 6'h10;
   localparam logic [5:0] SEL_LAMP_MAX = 6'h28;
   localparam logic [6:0] FOCUS_MAX = 7'h64;
   localparam logic [7:0] SUPPLY_HI = 8'h1E;
   localparam logic [7:0] SUPPLY_LO = 8'h12;
   localparam logic [11:0] ANGLE_CENTRE = 12'h800;
   // ****************************************
   // apb register map (byte addresses)
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PEND = 8'h04;
   localparam logic [7:0] REG_KEYS = 8'h08;
   localparam logic [7:0] REG_RXPKT = 8'h0C;
   localparam logic [7:0] REG_RXDIAG = 8'h10;
   localparam logic [7:0] REG_LAMPST = 8'h14;
   localparam logic [7:0] REG_SUPPLY = 8'h18;
   localparam logic [7:0] REG_BAUD = 8'h1C;
   // key bits in REG_KEYS writes
   localparam int KEY_SEL = 0;
   localparam int KEY_UP = 1;
   localparam int KEY_DOWN = 2;
   localparam int KEY_COMMIT = 3;
   // diagnostic codes
   localparam logic [1:0] DIAG_OK = 2'h0;
   localparam logic [1:0] DIAG_BAD_ADDR = 2'h1;
   localparam logic [1:0] DIAG_BAD_CMD = 2'h2;
   localparam logic [1:0] DIAG_CHK_ERR = 2'h3;

   typedef enum {
      MENU_DEFAULT, MENU_PANEL, MENU_LAMP, MENU_CHECK, MENU_SWITCH,
      MENU_PAN, MENU_TILT, MENU_FOCUS, MENU_EXT, MENU_SUPPLY
   } lbgcr_menu_e;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] cmd;
      logic [7:0] d0;
      logic [7:0] d1;
   } lbgcr_cmd_s;

   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } lbgcr_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lbgcr_apb_rsp_s;
endpackage : lbgcr_pkg

// ---- rtl/lbgcr_uart_rx.sv ----
// serial byte receiver, 8 data bits, one start and one stop bit
`timescale 1ns/10ps
module lbgcr_uart_rx
#(
   parameter int DIV_W = 16
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic rxPin,
   input wire logic [DIV_W-1:0] bitDiv,
   output logic [7:0] byteData,
   output logic byteValid
);
   import lbgcr_pkg::*;

   logic rxMeta_ff;
   logic rxSync_ff;
   logic [DIV_W-1:0] cnt_ff;
   logic [3:0] bitIdx_ff;
   logic busy_ff;
   logic [7:0] shift_ff;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rxMeta_ff <= 1'b1;
         rxSync_ff <= 1'b1;
      end
      else
      begin
         rxMeta_ff <= rxPin;
         rxSync_ff <= rxMeta_ff;
      end
   end

   // lsb first, start bit low, stop bit high
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
         bitIdx_ff <= 4'h0;
         shift_ff <= 8'h00;
         byteValid <= 1'b0;
         byteData <= 8'h00;
      end
      else
      begin
         byteValid <= 1'b0;
         if (!busy_ff)
         begin
            if (!rxSync_ff)
            begin
               busy_ff <= 1'b1;
               cnt_ff <= bitDiv >> 1;
               bitIdx_ff <= 4'h0;
            end
         end
         else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
         else
         begin
            cnt_ff <= bitDiv - 1'b1; // a bit lasts bitDiv cycles, not one more
            bitIdx_ff <= bitIdx_ff + 4'h1;
            if (bitIdx_ff == 4'h0)
               busy_ff <= !rxSync_ff; // false start rejected
            else if (bitIdx_ff <= 4'(DATA_BITS))
               shift_ff <= {rxSync_ff, shift_ff[7:1]};
            else
            begin
               busy_ff <= 1'b0;
               byteValid <= rxSync_ff; // framing error drops the byte
               byteData <= shift_ff;
            end
         end
      end
   end
endmodule : lbgcr_uart_rx

// ---- verification/lbgcr_ctrl_model.sv ----
// serial controller model driving the gateway receive line
`timescale 1ns/10ps
module lbgcr_ctrl_model
(
   input wire logic core_clk,
   output logic rxPin
);
   // ****
   // idle high line, talks only when told
   // ****
   initial rxPin = 1'b1;
   // bits move just after an edge, never between edges
   task send(input logic [7:0] b, input int bitCyc);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
         repeat (bitCyc) @(posedge core_clk) rxPin <= frame[i];
   endtask : send
endmodule : lbgcr_ctrl_model

// ---- verification/lbgcr_gateway_bench.sv ----
// bench: serial packets, menu keys and register checks for the gateway
`timescale 1ns/10ps
module lbgcr_gateway_bench;
   import lbgcr_pkg::*;
   // ****
   // signals
   // ****
   localparam int BC = 16;
   logic core_clk = 1'b0, reset = 1'b1, rxPin, txPin, busOk = 1'b1, lampResponding = 1'b1, se;
   lbgcr_apb_req_s apbReq = '0;
   lbgcr_apb_rsp_s apbRsp;
   lbgcr_cmd_s extCmd, localCmd, c;
   logic [7:0] lampStatus = 8'h0, supplyVolts = 8'h18;
   logic [3:0] panelAddr;
   logic [5:0] selLamp;
   logic [31:0] r, mk, noteQ[$], maskQ[$];
   logic [7:0] volts[4] = '{8'h1F, 8'h1E, 8'h12, 8'h11};
   logic hiLo[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   int errors = 0, totalChecks = 0, cyc = 0;
   // short timeout so the reject path is reached quickly
   lbgcr_gateway #(.TIMEOUT_CYC(2000)) i_lbgcr_gateway (.core_clk, .reset, .rxPin, .txPin,
      .apbReq, .apbRsp, .lampStatus, .lampResponding, .busOk, .supplyVolts, .extCmd,
      .localCmd, .panelAddr, .selLamp);
   lbgcr_ctrl_model i_lbgcr_ctrl_model (.core_clk, .rxPin);
   initial
      forever #5 core_clk = ~core_clk;
   // ****
   // tasks
   // ****
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      totalChecks++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : check
   task stopTest;
      if (errors == 0 && totalChecks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stopTest
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      apbReq <= '{{24'h0, a}, 1'b1, 1'b0, w, d};
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
      r = apbRsp.prdata;
      se = apbRsp.pslverr;
      apbReq <= '0;
   endtask : apb
   task key(input int k);
      apb(REG_KEYS, 1'b1, 32'h1 << k);
   endtask : key
   task note(input logic [31:0] e, input logic [31:0] m);
      noteQ.push_back(e);
      maskQ.push_back(m);
   endtask : note
   // note goes in before the check byte, which launches the result
   task pkt(input logic [7:0] b[$], input logic bad, input logic [31:0] m);
      logic [7:0] s;
      logic [31:0] e;
      s = 8'h0;
      e = '0;
      foreach (b[i])
      begin
         s += b[i];
         if (i > 0 && i < 5)
            e[39-8*i -: 8] = b[i];
         i_lbgcr_ctrl_model.send(b[i], BC);
      end
      if (m != 0)
         note(e, m);
      i_lbgcr_ctrl_model.send({1'b0, s[6:0] ^ {6'h0, bad}}, BC);
   endtask : pkt
   // ****
   // result watcher and run limit
   // ****
   always @(posedge core_clk)
      if (extCmd.valid === 1'b1 || localCmd.valid === 1'b1)
      begin
         c = (extCmd.valid === 1'b1) ? extCmd : localCmd;
         if (noteQ.size() == 0)
            check("unexpected", 32'h1, 32'h0);
         else
         begin
            mk = maskQ.pop_front();
            check("cmd", {c.addr, c.cmd, c.d0, c.d1} & mk, noteQ.pop_front() & mk);
         end
      end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         stopTest();
      end
   end
   // ****
   // main sequence
   // ****
   initial
   begin
      void'($urandom(32'hE7A7E36D));
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      check("tx", txPin, 32'h1);
      check("sel", selLamp, 32'h10);
      apb(REG_CTRL, 1'b0, 32'h0);
      check("ctrl", r, 32'h1010);
      apb(REG_BAUD, 1'b1, BC);
      apb(REG_BAUD, 1'b0, 32'h0);
      check("baud", r, BC);
      apb(8'h40, 1'b0, 32'h0);
      check("unmapped", se, 32'h1);
      lampStatus <= 8'($urandom);
      pkt('{8'hFF, 8'h90, CMD_FOCUS}, 1'b0, 32'hFFFF0000);
      pkt('{8'hFF, 8'h92, CMD_TILT_UP, 8'($urandom % 128)}, 1'b0, 32'hFFFFFF00);
      pkt('{8'hFF, 8'hA8, CMD_PAN_POS, 8'h0A, 8'h08}, 1'b0, 32'hFFFFFFFF);
      pkt('{8'hFF, 8'h90, CMD_LAMP_ON}, 1'b1, 32'h0);
      apb(REG_RXDIAG, 1'b0, 32'h0);
      check("diag", r[9:8], DIAG_CHK_ERR);
      pkt('{8'hFF, 8'h80, CMD_LAMP_ON}, 1'b0, 32'h0);
      apb(REG_RXDIAG, 1'b0, 32'h0);
      check("diag", r[9:8], DIAG_BAD_ADDR);
      pkt('{8'hFF, 8'h90, 8'h0A}, 1'b0, 32'h0);
      apb(REG_RXDIAG, 1'b0, 32'h0);
      check("diag", r[9:8], DIAG_BAD_CMD);
      apb(REG_LAMPST, 1'b0, 32'h0);
      check("lampst", r, {22'h0, busOk, lampResponding, lampStatus});
      i_lbgcr_ctrl_model.send(8'hFF, BC);
      i_lbgcr_ctrl_model.send(8'h90, BC);
      pkt('{8'hFF, 8'h91, CMD_LAMP_OFF}, 1'b0, 32'hFFFF0000);
      i_lbgcr_ctrl_model.send(8'hFF, BC);
      i_lbgcr_ctrl_model.send(8'h90, BC);
      repeat (2500) @(posedge core_clk);
      i_lbgcr_ctrl_model.send(CMD_FOCUS, BC);
      i_lbgcr_ctrl_model.send(8'h1A, BC);
      key(KEY_SEL);
      key(KEY_UP);
      check("hold", panelAddr, 32'h0);
      key(KEY_COMMIT);
      repeat (3) @(posedge core_clk);
      check("panel", panelAddr, 32'h1);
      key(KEY_SEL);
      key(KEY_UP);
      key(KEY_COMMIT);
      key(KEY_SEL);
      check("lamp", selLamp, 32'h11);
      key(KEY_UP);
      key(KEY_COMMIT);
      // checking now off: a bad check byte must still pass
      pkt('{8'hFF, 8'h93, CMD_HOME}, 1'b1, 32'hFFFF0000);
      key(KEY_SEL);
      key(KEY_UP);
      note({8'h91, CMD_LAMP_ON, 16'h0}, 32'hFFFF0000);
      key(KEY_COMMIT);
      key(KEY_SEL);
      key(KEY_UP);
      note({8'h91, CMD_PAN_POS, 16'h0108}, 32'hFFFFFFFF);
      key(KEY_COMMIT);
      key(KEY_SEL);
      note({8'h91, CMD_TILT_POS, 16'h0008}, 32'hFFFFFFFF);
      key(KEY_COMMIT);
      key(KEY_SEL);
      repeat (100)
      begin
         note({8'h91, CMD_FOCUS, 16'h0}, 32'hFFFF0000);
         key(KEY_UP);
      end
      apb(REG_PEND, 1'b0, 32'h0);
      check("focus", r[14:8], 32'h64);
      note({8'h91, CMD_FOCUS, 16'h0}, 32'hFFFF0000);
      key(KEY_UP);
      apb(REG_PEND, 1'b0, 32'h0);
      check("wrap", r[14:8], 32'h0);
      foreach (volts[i])
      begin
         supplyVolts <= volts[i];
         repeat (4) @(posedge core_clk);
         apb(REG_SUPPLY, 1'b0, 32'h0);
         check("supply", r[8], hiLo[i]);
      end
      repeat (20) @(posedge core_clk);
      check("left", noteQ.size(), 32'h0);
      stopTest();
   end
endmodule : lbgcr_gateway_bench
